/* File: host_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
module host_core_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic go,
  input wire logic [3:0] delay,
  input wire logic irq_out,
  input wire logic vector_valid,
  input wire logic [7:0] vector,
  output logic irq_acknowledge,
  output logic got,
  output logic [7:0] vec
);
  logic armed_reg;
  logic [3:0] wait_reg;
  // one acknowledge per arming, after a chosen number of cycles
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      armed_reg <= 1'b0;
      wait_reg <= 4'h0;
      irq_acknowledge <= 1'b0;
      got <= 1'b0;
      vec <= 8'h00;
    end else begin
      got <= vector_valid;
      if (vector_valid) begin
        vec <= vector;
        irq_acknowledge <= 1'b0;
      end
      if (go) begin
        armed_reg <= 1'b1;
        wait_reg <= delay;
      end else if (armed_reg && irq_out && wait_reg != 4'h0) begin
        wait_reg <= wait_reg - 4'h1;
      end else if (armed_reg && irq_out) begin
        irq_acknowledge <= 1'b1;
        armed_reg <= 1'b0;
      end
    end
  end
endmodule : host_core_model
`default_nettype wire

/* File: vectored_priority_interrupt_unit.sv */
`timescale 1ns/1ns
`default_nettype none
module vectored_priority_interrupt_unit #(
  parameter int LINES = vpiu_pkg::NUM_LINES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [LINES-1:0] irq_lines,
  input wire logic nmi_in,
  input wire vpiu_pkg::io_req_s io_req,
  input wire logic irq_acknowledge,
  output logic irq_out,
  output logic nmi_out,
  output vpiu_pkg::io_rsp_s io_rsp
);
  import vpiu_pkg::*;

  if (LINES != 8) begin : g_lines_check
    $error("only eight request lines are supported");
  end

  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] prev;
    logic nmi1;
    logic nmi2;
    logic [7:0] mask;
    logic [7:0] edge_sel;
    logic [7:0] base;
    prio_mode_e mode;
    logic [2:0] lowest;
    logic [7:0] pend;
    logic [7:0] isr;
    logic ack_prev;
    logic [7:0] rdata;
    logic [7:0] vector;
    logic vector_valid;
  } state_s;

  state_s st_reg, st_next;

  // level of line i relative to the lowest; the lowest line ranks 0, the one after it 7
  function automatic logic [2:0] rank(input logic [2:0] line, input logic [2:0] low);
    rank = 3'(low - line);
  endfunction : rank

  logic [7:0] req;
  logic [2:0] low_eff;
  logic [2:0] best_line;
  logic best_ok;
  logic [2:0] best_rank;
  logic [2:0] isr_rank;
  logic isr_any;
  logic ack_rise;

  // request candidates and arbitration
  always_comb begin
    req = (st_reg.pend | (~st_reg.edge_sel & st_reg.sync2)) & ~st_reg.mask;
    low_eff = (st_reg.mode == MODE_NESTED || st_reg.mode == MODE_POLLED) ? 3'h7
              : st_reg.lowest;
    best_ok = 1'b0;
    best_line = 3'h0;
    best_rank = 3'h0;
    isr_any = 1'b0;
    isr_rank = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (req[i] && (!best_ok || rank(3'(i), low_eff) > best_rank)) begin
        best_ok = 1'b1;
        best_line = 3'(i);
        best_rank = rank(3'(i), low_eff);
      end
      if (st_reg.isr[i] && (!isr_any || rank(3'(i), low_eff) > isr_rank)) begin
        isr_any = 1'b1;
        isr_rank = rank(3'(i), low_eff);
      end
    end
    ack_rise = irq_acknowledge && !st_reg.ack_prev;
  end

  // forward only when outranking service in progress
  assign irq_out = best_ok && (st_reg.mode != MODE_POLLED)
                   && (!isr_any || best_rank > isr_rank);
  assign nmi_out = st_reg.nmi2;
  assign io_rsp = '{rdata: st_reg.rdata, vector: st_reg.vector,
                    vector_valid: st_reg.vector_valid};

  // next state
  always_comb begin
    st_next = st_reg;
    st_next.sync1 = irq_lines;
    st_next.sync2 = st_reg.sync1;
    st_next.prev = st_reg.sync2;
    st_next.nmi1 = nmi_in;
    st_next.nmi2 = st_reg.nmi1;
    st_next.ack_prev = irq_acknowledge;
    st_next.vector_valid = 1'b0;
    // level lines drop pending here; the edge set at the end wins over any clear
    st_next.pend = st_reg.pend & st_reg.edge_sel;
    // configuration writes at any time
    if (io_req.wr) begin
      unique case (io_req.addr)
        PORT_MASK: st_next.mask = io_req.wdata;
        PORT_MODE: st_next.mode = prio_mode_e'(io_req.wdata[1:0]);
        PORT_LOWEST: st_next.lowest = io_req.wdata[2:0];
        PORT_BASE: st_next.base = io_req.wdata;
        PORT_EDGE: st_next.edge_sel = io_req.wdata;
        PORT_EOI: begin
          st_next.isr = st_reg.isr & ~io_req.wdata;
        end
        default: ;
      endcase
    end
    // polled read takes the request as serviced
    if (io_req.rd) begin
      unique case (io_req.addr)
        PORT_MASK: st_next.rdata = st_reg.mask;
        PORT_MODE: st_next.rdata = {6'h00, st_reg.mode};
        PORT_LOWEST: st_next.rdata = {5'h00, st_reg.lowest};
        PORT_BASE: st_next.rdata = st_reg.base;
        PORT_EDGE: st_next.rdata = st_reg.edge_sel;
        PORT_EOI: st_next.rdata = st_reg.isr;
        PORT_POLL: begin
          st_next.rdata = {best_ok, 4'h0, best_line};
          if (best_ok) begin
            st_next.pend[best_line] = 1'b0;
            if (st_reg.mode == MODE_ROTATE) st_next.lowest = best_line;
          end
        end
        PORT_PEND: st_next.rdata = req;
        default: st_next.rdata = 8'h00;
      endcase
    end
    // acknowledge: vector out, line goes in service
    if (ack_rise && irq_out) begin
      st_next.vector = {st_reg.base[7:3], best_line};
      st_next.vector_valid = 1'b1;
      st_next.pend[best_line] = 1'b0;
      st_next.isr[best_line] = 1'b1;
      if (st_reg.mode == MODE_ROTATE) st_next.lowest = best_line;
    end
    st_next.pend = st_next.pend | (st_reg.edge_sel & st_reg.sync2 & ~st_reg.prev);
  end

  // state register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.mask <= MASK_RST;
      st_reg.base <= BASE_RST;
      st_reg.lowest <= LOWEST_RST;
      st_reg.edge_sel <= EDGE_RST;
      st_reg.mode <= MODE_NESTED;
    end else begin
      st_reg <= st_next;
    end
  end

  // checks
  property p_nmi_pass;
    @(posedge clock) disable iff (rst) nmi_in |-> ##2 nmi_out;
  endproperty
  a_nmi_pass: assert property (p_nmi_pass) else $error("nmi not forwarded");
  property p_mask_blocks;
    @(posedge clock) disable iff (rst) (st_reg.mask == 8'hFF) |-> !irq_out;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked line raised irq");
  property p_vector;
    @(posedge clock) disable iff (rst) (ack_rise && irq_out)
      |=> io_rsp.vector_valid && io_rsp.vector[2:0] == $past(best_line);
  endproperty
  a_vector: assert property (p_vector) else $error("vector wrong");
  property p_vec_pulse;
    @(posedge clock) disable iff (rst) io_rsp.vector_valid |=> !io_rsp.vector_valid;
  endproperty
  a_vec_pulse: assert property (p_vec_pulse) else $error("vector valid too long");
  property p_polled_quiet;
    @(posedge clock) disable iff (rst) (st_reg.mode == MODE_POLLED) |-> !irq_out;
  endproperty
  a_polled_quiet: assert property (p_polled_quiet) else $error("irq in polled mode");
  property p_nested_top;
    @(posedge clock) disable iff (rst)
      (st_reg.mode == MODE_NESTED && req[0] && st_reg.isr == 8'h00) |-> irq_out && best_line == 3'h0;
  endproperty
  a_nested_top: assert property (p_nested_top) else $error("line 0 not highest");
  property p_rotate;
    @(posedge clock) disable iff (rst)
      (st_reg.mode == MODE_ROTATE && ack_rise && irq_out && !io_req.rd)
      |=> st_reg.lowest == $past(best_line);
  endproperty
  a_rotate: assert property (p_rotate) else $error("served line not lowest");
  property p_nested_block;
    @(posedge clock) disable iff (rst)
      (st_reg.mode == MODE_NESTED && st_reg.isr[0]) |-> !irq_out;
  endproperty
  a_nested_block: assert property (p_nested_block) else $error("irq over line 0 service");
  property p_mask_write;
    @(posedge clock) disable iff (rst) (io_req.wr && io_req.addr == PORT_MASK)
      |=> st_reg.mask == $past(io_req.wdata);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask not taken");

  c_ack: cover property (@(posedge clock) disable iff (rst) ack_rise && irq_out);
  c_poll: cover property (@(posedge clock) disable iff (rst)
    io_req.rd && io_req.addr == PORT_POLL && best_ok);
  c_rot: cover property (@(posedge clock) disable iff (rst)
    st_reg.mode == MODE_ROTATE && ack_rise && irq_out);
  c_nest: cover property (@(posedge clock) disable iff (rst)
    st_reg.mode == MODE_NESTED && isr_any && irq_out);
endmodule : vectored_priority_interrupt_unit
`default_nettype wire

/* File: vectored_priority_interrupt_unit_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module vectored_priority_interrupt_unit_tb;
  import vpiu_pkg::*;
  logic clock, rst, nmi_in, go, irq_out, nmi_out, irq_acknowledge, got;
  logic [7:0] irq_lines, vec, rd_val, v, base;
  logic [3:0] delay;
  io_req_s io_req;
  io_rsp_s io_rsp;
  int miscompares, comparisons, cycles, low;
  vectored_priority_interrupt_unit dut (.clock(clock), .rst(rst), .irq_lines(irq_lines),
    .nmi_in(nmi_in), .io_req(io_req), .irq_acknowledge(irq_acknowledge), .irq_out(irq_out),
    .nmi_out(nmi_out), .io_rsp(io_rsp));
  host_core_model host (.clock(clock), .rst(rst), .go(go), .delay(delay), .irq_out(irq_out),
    .vector_valid(io_rsp.vector_valid), .vector(io_rsp.vector),
    .irq_acknowledge(irq_acknowledge), .got(got), .vec(vec));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // cycle ceiling against hangs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic close_out();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic check(logic [7:0] g, logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : check
  // one io cycle; read data sampled mid cycle
  task automatic io(logic w, logic [2:0] a, logic [7:0] d);
    io_req <= '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge clock);
    io_req <= '0;
    @(posedge clock);
    @(negedge clock);
    rd_val = io_rsp.rdata;
    @(posedge clock);
  endtask : io
  function automatic int winner(logic [7:0] r, int lowest);
    for (int k = 1; k <= 8; k++) if (r[(lowest + k) % 8]) return (lowest + k) % 8;
    return 0;
  endfunction : winner
  // raise requests, let the host acknowledge, compare the vector
  task automatic serve(logic [7:0] r, int line, logic keep, logic [3:0] d);
    irq_lines <= r;
    delay <= d;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    for (int k = 0; k < 40 && got !== 1'b1; k++) @(negedge clock);
    check({7'h0, got}, 8'h01);
    check(vec, {base[7:3], 3'(line)});
    @(posedge clock);
    if (!keep) begin
      irq_lines <= 8'h00;
      repeat (3) @(posedge clock);
      io(1'b1, PORT_EOI, 8'hFF);
    end
  endtask : serve
  initial begin
    rst = 1'b1;
    nmi_in = 1'b0;
    go = 1'b0;
    delay = 4'h0;
    irq_lines = 8'h00;
    io_req = '0;
    void'($urandom(13));
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    io(1'b0, PORT_MASK, 8'h00);
    check(rd_val, MASK_RST);
    io(1'b0, PORT_LOWEST, 8'h00);
    check(rd_val, {5'h0, LOWEST_RST});
    io(1'b0, PORT_EDGE, 8'h00);
    check(rd_val, EDGE_RST);
    // all masked: no irq reaches the processor, only nmi passes
    irq_lines <= 8'hFF;
    nmi_in <= 1'b1;
    @(posedge clock);
    @(negedge clock);
    check({7'h0, nmi_out}, 8'h00);
    @(negedge clock);
    check({7'h0, nmi_out}, 8'h01);
    check({7'h0, irq_out}, 8'h00);
    @(posedge clock);
    base = 8'($urandom);
    io(1'b1, PORT_BASE, base);
    io(1'b1, PORT_MASK, 8'hFE);
    // line 0 unmasked and still high: it alone reaches the processor
    @(negedge clock);
    check({7'h0, irq_out}, 8'h01);
    @(posedge clock);
    serve(8'hFF, 0, 1'b0, 4'h1);
    io(1'b1, PORT_MASK, 8'h00);
    // line 5 waits behind line 3, line 1 preempts
    serve(8'h08, 3, 1'b1, 4'h0);
    irq_lines <= 8'h28;
    io(1'b0, PORT_EOI, 8'h00);
    check(rd_val, 8'h08);
    @(negedge clock);
    check({7'h0, irq_out}, 8'h00);
    @(posedge clock);
    serve(8'h2A, 1, 1'b0, 4'h2);
    // short edge pulse latched, slow host
    io(1'b1, PORT_EDGE, 8'h10);
    irq_lines <= 8'h10;
    repeat (2) @(posedge clock);
    serve(8'h00, 4, 1'b0, 4'h6);
    io(1'b1, PORT_EDGE, 8'h00);
    // random traffic across modes changed on the fly
    for (int i = 0; i < 30; i++) begin
      io(1'b1, PORT_MODE, 8'(i % 3));
      v = 8'($urandom_range(1, 255));
      low = 7;
      if (i % 3 == 2) begin
        low = $urandom_range(0, 7);
        io(1'b1, PORT_LOWEST, 8'(low));
      end
      if (i % 3 == 1) begin
        low = $urandom_range(0, 7);
        serve(8'h01 << low, low, 1'b0, 4'(i % 7));
      end
      serve(v, winner(v, low), 1'b0, 4'($urandom_range(0, 6)));
    end
    // polled status read
    io(1'b1, PORT_MODE, 8'h03);
    irq_lines <= v;
    repeat (4) @(posedge clock);
    io(1'b0, PORT_POLL, 8'h00);
    check(rd_val, {5'h10, 3'(winner(v, 7))});
    close_out();
  end
endmodule : vectored_priority_interrupt_unit_tb
`default_nettype wire

/* File: vpiu_pkg.sv */
`default_nettype none
package vpiu_pkg;
  // io port map of the controller, byte wide data
  localparam logic [2:0] PORT_MASK = 3'h0;
  localparam logic [2:0] PORT_MODE = 3'h1;
  localparam logic [2:0] PORT_LOWEST = 3'h2;
  localparam logic [2:0] PORT_BASE = 3'h3;
  localparam logic [2:0] PORT_EDGE = 3'h4;
  localparam logic [2:0] PORT_EOI = 3'h5;
  localparam logic [2:0] PORT_POLL = 3'h6;
  localparam logic [2:0] PORT_PEND = 3'h7;
  // reset values
  localparam logic [7:0] MASK_RST = 8'hFF;
  localparam logic [7:0] BASE_RST = 8'h00;
  localparam logic [2:0] LOWEST_RST = 3'h7;
  localparam logic [7:0] EDGE_RST = 8'h00;
  localparam int NUM_LINES = 8;
  localparam int TOTAL_LEVELS = 65;

  typedef enum logic [1:0] {
    MODE_NESTED,
    MODE_ROTATE,
    MODE_SPECIFIC,
    MODE_POLLED
  } prio_mode_e;

  // processor side io cycle
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } io_req_s;

  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] vector;
    logic vector_valid;
  } io_rsp_s;
endpackage : vpiu_pkg
`default_nettype wire
